// *** pkg/amd_pkg.sv ***
package amd_pkg;
    // addressing mode codes: 17 modes in 7 families
    typedef enum logic [4:0] {
        AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX_0, AM_IDX_S, AM_IDX_L,
        AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_D, AM_REL_I,
        AM_BIT_D, AM_BIT_I, AM_BTJ_D, AM_BTJ_I
    } amd_mode_t;

    // families
    typedef enum logic [2:0] {
        FAM_INH, FAM_IMM, FAM_DIR, FAM_IDX, FAM_IND, FAM_REL, FAM_BIT
    } amd_fam_t;

    // request from fetch: mode plus operand bytes and index values
    typedef struct packed {
        amd_mode_t mode;
        logic rmw;
        logic use_y;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [7:0] idx_x;
        logic [7:0] idx_y;
    } amd_req_t;

    // result handed back to execute
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] imm;
        logic [1:0] nbytes;
        amd_fam_t fam;
        logic is_imm;
        logic illegal;
    } amd_res_t;

    localparam logic [15:0] PAGE0_TOP = 16'h00ff;
    localparam logic [15:0] SHORT_IDX_TOP = 16'h01fe;
    localparam logic [1:0] PTR_WORD_BYTES = 2'h2;
endpackage

// *** design/amd_ptr_fetch.sv ***
`timescale 1ns/1ps
// reads a one- or two-byte pointer from page zero over the memory port
module amd_ptr_fetch
    import amd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // request
    input wire logic start,
    input wire logic word,
    input wire logic [7:0] ptr_addr,
    // memory port
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // result
    output logic done,
    output logic [15:0] ptr
);
    typedef enum logic [1:0] {PF_IDLE, PF_HI, PF_LO} amd_pf_t;
    amd_pf_t st_q;
    logic [7:0] pa_q;

    // sequencer: high byte first for a word, as big-endian pointers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= PF_IDLE;
            pa_q <= 8'h00;
            mem_rd <= 1'b0;
            mem_addr <= 16'h0000;
            done <= 1'b0;
            ptr <= 16'h0000;
        end
        else
        begin
            done <= 1'b0;
            unique case (st_q)
                PF_IDLE:
                begin
                    if (start)
                    begin
                        pa_q <= ptr_addr;
                        mem_rd <= 1'b1;
                        mem_addr <= {8'h00, ptr_addr};
                        st_q <= word ? PF_HI : PF_LO;
                    end
                end
                PF_HI:
                begin
                    if (mem_ack)
                    begin
                        // second byte stays in page zero, wraps at ff
                        ptr[15:8] <= mem_rdata;
                        mem_addr <= {8'h00, pa_q + 8'h01};
                        st_q <= PF_LO;
                    end
                end
                PF_LO:
                begin
                    if (mem_ack)
                    begin
                        if (mem_addr[7:0] == pa_q)
                            ptr <= {8'h00, mem_rdata};
                        else
                            ptr[7:0] <= mem_rdata;
                        mem_rd <= 1'b0;
                        done <= 1'b1;
                        st_q <= PF_IDLE;
                    end
                end
                // unused code: fall back to idle rather than hang
                default: st_q <= PF_IDLE;
            endcase
        end
    end
endmodule

// *** design/amd_decoder.sv ***
`timescale 1ns/1ps
// How it works
// RL1 - seventeen modes in seven families
// RL2 - long forms reach full 64k space
// RL3 - short direct forms reach page zero only
// RL4 - read-modify-write takes short forms only
// RL5 - inherent: one byte, no operand
// RL6 - immediate: second byte is operand value
// RL7 - short direct: one address byte
// RL8 - long direct: two bytes form address
// RL9 - indexed: index plus offset, x or y
// RL10 - no-offset indexed: address is index
// RL11 - short indexed: byte offset, to 1fe
// RL12 - long indexed: word offset plus index
// RL13 - indirect: fetch pointer from byte address
// RL14 - short indirect: byte pointer, page zero
// RL15 - indirect indexed: pointer plus index
// RL16 - short indirect indexed: up to 1fe
// RL17 - long indirect: two-byte page-zero pointer
// RL18 - short index sums keep ninth bit
module amd_decoder
    import amd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // request from fetch
    input wire logic req_valid,
    input wire amd_req_t req,
    output logic req_ready,
    // memory port for pointer reads
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // result to execute
    output logic res_valid,
    output amd_res_t res
);
    typedef enum logic [1:0] {DC_IDLE, DC_PTR, DC_DONE} amd_st_t;
    amd_st_t st_q;
    amd_req_t req_q;
    logic pf_done;
    logic [15:0] pf_ptr;
    logic pf_start;

    // bytes after the opcode per mode
    function automatic logic [1:0] op_bytes(input amd_mode_t m);
        unique case (m)
            AM_INH, AM_IDX_0: op_bytes = 2'h0; // [RL5] [RL10]
            AM_IMM, AM_DIR_S, AM_IDX_S, AM_REL_D, AM_BIT_D: op_bytes = 2'h1; // [RL6] [RL7] [RL11]
            AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_I, AM_BIT_I: op_bytes = 2'h1; // [RL14] [RL16]
            AM_DIR_L, AM_IDX_L, AM_BTJ_D, AM_BTJ_I: op_bytes = 2'h2; // [RL8] [RL12]
            // codes past the last mode: no operand bytes
            default: op_bytes = 2'h0;
        endcase
    endfunction

    // family of each mode
    function automatic amd_fam_t fam_of(input amd_mode_t m);
        unique case (m)
            AM_INH: fam_of = FAM_INH; // [RL1]
            AM_IMM: fam_of = FAM_IMM;
            AM_DIR_S, AM_DIR_L: fam_of = FAM_DIR;
            AM_IDX_0, AM_IDX_S, AM_IDX_L: fam_of = FAM_IDX;
            AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L: fam_of = FAM_IND;
            AM_REL_D, AM_REL_I: fam_of = FAM_REL;
            AM_BIT_D, AM_BIT_I, AM_BTJ_D, AM_BTJ_I: fam_of = FAM_BIT;
            default: fam_of = FAM_INH;
        endcase
    endfunction

    // modes that need a pointer from memory
    function automatic logic needs_ptr(input amd_mode_t m);
        needs_ptr = (m == AM_IND_S) || (m == AM_IND_L) || (m == AM_IIX_S) || (m == AM_IIX_L)
            || (m == AM_REL_I) || (m == AM_BIT_I) || (m == AM_BTJ_I); // [RL13]
    endfunction

    // long forms, refused for read-modify-write
    function automatic logic is_long(input amd_mode_t m);
        is_long = (m == AM_DIR_L) || (m == AM_IDX_L) || (m == AM_IND_L) || (m == AM_IIX_L);
    endfunction

    // index register chosen by the prebyte
    function automatic logic [7:0] idx_of(input amd_req_t r);
        idx_of = r.use_y ? r.idx_y : r.idx_x; // [RL9]
    endfunction

    // address for modes with no pointer
    function automatic logic [15:0] direct_addr(input amd_req_t r);
        logic [7:0] ix;
        ix = idx_of(r);
        unique case (r.mode)
            AM_DIR_S, AM_BIT_D, AM_BTJ_D: direct_addr = {8'h00, r.op1}; // [RL3] [RL7]
            AM_DIR_L: direct_addr = {r.op1, r.op2}; // [RL2] [RL8]
            AM_IDX_0: direct_addr = {8'h00, ix}; // [RL10]
            AM_IDX_S: direct_addr = {7'h00, {1'b0, r.op1} + {1'b0, ix}}; // [RL11] [RL18]
            AM_IDX_L: direct_addr = {r.op1, r.op2} + {8'h00, ix}; // [RL12]
            default: direct_addr = 16'h0000;
        endcase
    endfunction

    // pointer fetch helper
    assign pf_start = (st_q == DC_IDLE) && req_valid && needs_ptr(req.mode) && !(req.rmw && is_long(req.mode));

    amd_ptr_fetch u_ptr (
        .mclk(mclk),
        .rstn(rstn),
        .start(pf_start),
        .word(req.mode == AM_IND_L || req.mode == AM_IIX_L), // [RL17]
        .ptr_addr(req.op1), // [RL13]
        .mem_rd(mem_rd),
        .mem_addr(mem_addr),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata),
        .done(pf_done),
        .ptr(pf_ptr)
    );

    // control flow: one request at a time, ready only when idle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= DC_IDLE;
            req_q <= '0;
            req_ready <= 1'b1;
        end
        else
        begin
            unique case (st_q)
                DC_IDLE:
                begin
                    if (req_valid)
                    begin
                        req_q <= req;
                        req_ready <= 1'b0;
                        st_q <= pf_start ? DC_PTR : DC_DONE;
                    end
                end
                DC_PTR:
                begin
                    if (pf_done)
                        st_q <= DC_DONE;
                end
                DC_DONE:
                begin
                    // result issued this cycle, take next request after
                    req_ready <= 1'b1;
                    st_q <= DC_IDLE;
                end
                // unused code: recover to idle and reopen
                default:
                begin
                    req_ready <= 1'b1;
                    st_q <= DC_IDLE;
                end
            endcase
        end
    end

    // result builder
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            res_valid <= 1'b0;
            res <= '0;
        end
        else
        begin
            res_valid <= 1'b0;
            if (st_q == DC_IDLE && req_valid && !pf_start)
            begin
                res_valid <= 1'b1;
                res.fam <= fam_of(req.mode); // [RL1]
                res.nbytes <= op_bytes(req.mode);
                res.is_imm <= (req.mode == AM_IMM); // [RL6]
                res.imm <= (req.mode == AM_IMM) ? req.op1 : 8'h00;
                // pointer modes only reach here when refused
                res.illegal <= req.rmw && is_long(req.mode); // [RL4]
                res.addr <= (req.mode == AM_INH || req.mode == AM_IMM) ? 16'h0000 : direct_addr(req); // [RL5]
            end
            else if (st_q == DC_PTR && pf_done)
            begin
                res_valid <= 1'b1;
                res.fam <= fam_of(req_q.mode);
                res.nbytes <= op_bytes(req_q.mode);
                res.is_imm <= 1'b0;
                res.imm <= 8'h00;
                res.illegal <= 1'b0;
                unique case (req_q.mode)
                    AM_IIX_S: res.addr <= {7'h00, {1'b0, pf_ptr[7:0]} + {1'b0, idx_of(req_q)}}; // [RL16] [RL18]
                    AM_IIX_L: res.addr <= pf_ptr + {8'h00, idx_of(req_q)}; // [RL15] [RL17]
                    default: res.addr <= pf_ptr; // [RL14] [RL17]
                endcase
            end
        end
    end

    // checks
    chk_short_direct_page: assert property (@(posedge mclk) disable iff (!rstn) // [RL7]
        (st_q == DC_IDLE && req_valid && req.mode == AM_DIR_S) |=> res_valid && res.addr <= PAGE0_TOP)
        else $error("short direct left page zero");
    chk_short_idx_sum: assert property (@(posedge mclk) disable iff (!rstn) // [RL11]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IDX_S)
        |=> res.addr == {7'h00, {1'b0, $past(req.op1)} + {1'b0, $past(idx_of(req))}})
        else $error("short indexed sum wrong");
    chk_short_idx_top: assert property (@(posedge mclk) disable iff (!rstn) // [RL18]
        (res_valid && req_q.mode == AM_IDX_S) |-> res.addr <= SHORT_IDX_TOP)
        else $error("short indexed beyond 1fe");
    chk_long_direct_addr: assert property (@(posedge mclk) disable iff (!rstn) // [RL8]
        (st_q == DC_IDLE && req_valid && req.mode == AM_DIR_L && !req.rmw)
        |=> res.addr == {$past(req.op1), $past(req.op2)} && res.nbytes == 2'h2)
        else $error("long direct address wrong");
    chk_inherent_len: assert property (@(posedge mclk) disable iff (!rstn) // [RL5]
        (st_q == DC_IDLE && req_valid && req.mode == AM_INH) |=> res_valid && res.nbytes == 2'h0)
        else $error("inherent has operand bytes");
    chk_imm_value: assert property (@(posedge mclk) disable iff (!rstn) // [RL6]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IMM) |=> res.is_imm && res.imm == $past(req.op1))
        else $error("immediate value lost");
    chk_rmw_long_refused: assert property (@(posedge mclk) disable iff (!rstn) // [RL4]
        (st_q == DC_IDLE && req_valid && req.rmw && is_long(req.mode)) |=> res_valid && res.illegal && !mem_rd)
        else $error("long form taken for rmw");
    chk_ptr_fetch_bound: assert property (@(posedge mclk) disable iff (!rstn) // [RL13]
        (st_q == DC_IDLE && pf_start) |=> mem_rd && mem_addr[15:8] == 8'h00)
        else $error("pointer read not in page zero");
    chk_noff_index: assert property (@(posedge mclk) disable iff (!rstn) // [RL10]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IDX_0) |=> res.addr == {8'h00, $past(idx_of(req))})
        else $error("no-offset index address wrong");

    // handshake: ready exactly while idle, result is one pulse
    // idle always accepts
    chk_idle_ready: assert property (@(posedge mclk) disable iff (!rstn) // [RL1]
        (st_q == DC_IDLE) |-> req_ready)
        else $error("idle but not ready");
    // busy never accepts, so a second request cannot overwrite the first
    chk_busy_not_ready: assert property (@(posedge mclk) disable iff (!rstn) // [RL13]
        (st_q != DC_IDLE) |-> !req_ready)
        else $error("ready while busy");
    // result pulse lasts one cycle
    chk_res_single_pulse: assert property (@(posedge mclk) disable iff (!rstn) // [RL1]
        res_valid |=> !res_valid)
        else $error("result valid too long");
    // ready returns right after the result
    chk_ready_after_res: assert property (@(posedge mclk) disable iff (!rstn) // [RL13]
        res_valid |=> req_ready)
        else $error("ready late after result");

    // operand lengths and plain addresses
    // immediate carries one byte
    chk_imm_len: assert property (@(posedge mclk) disable iff (!rstn) // [RL6]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IMM) |=> res.nbytes == 2'h1)
        else $error("immediate length wrong");
    // inherent has no address and no immediate
    chk_inh_addr_zero: assert property (@(posedge mclk) disable iff (!rstn) // [RL5]
        (st_q == DC_IDLE && req_valid && req.mode == AM_INH) |=> res.addr == 16'h0000 && !res.is_imm)
        else $error("inherent produced an operand");
    // short direct: one byte after opcode
    chk_dir_short_len: assert property (@(posedge mclk) disable iff (!rstn) // [RL7]
        (st_q == DC_IDLE && req_valid && req.mode == AM_DIR_S) |=> res.nbytes == 2'h1)
        else $error("short direct length wrong");
    // no-offset indexed: nothing follows the opcode
    chk_idx0_len: assert property (@(posedge mclk) disable iff (!rstn) // [RL10]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IDX_0) |=> res.nbytes == 2'h0)
        else $error("no-offset indexed length wrong");
    // short indexed: one offset byte
    chk_idx_short_len: assert property (@(posedge mclk) disable iff (!rstn) // [RL11]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IDX_S) |=> res.nbytes == 2'h1)
        else $error("short indexed length wrong");
    // long indexed: word offset plus index, full 16-bit sum
    chk_idx_long_sum: assert property (@(posedge mclk) disable iff (!rstn) // [RL12]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IDX_L && !req.rmw)
        |=> res.addr == {$past(req.op1), $past(req.op2)} + {8'h00, $past(idx_of(req))})
        else $error("long indexed sum wrong");
    // bit operations on direct addresses stay in page zero
    chk_bit_direct_page: assert property (@(posedge mclk) disable iff (!rstn) // [RL3]
        (st_q == DC_IDLE && req_valid && (req.mode == AM_BIT_D || req.mode == AM_BTJ_D))
        |=> res.addr <= PAGE0_TOP)
        else $error("bit direct left page zero");
    // short forms are fine for read-modify-write
    chk_rmw_short_ok: assert property (@(posedge mclk) disable iff (!rstn) // [RL4]
        (st_q == DC_IDLE && req_valid && req.rmw && !is_long(req.mode) && !needs_ptr(req.mode))
        |=> res_valid && !res.illegal)
        else $error("short form refused for rmw");

    // pointer path
    // non-pointer modes never touch memory
    chk_direct_no_read: assert property (@(posedge mclk) disable iff (!rstn) // [RL7]
        (st_q == DC_IDLE && req_valid && !needs_ptr(req.mode)) |=> !mem_rd)
        else $error("memory read on a direct mode");
    // first pointer read goes to the page-zero address given by the byte after the opcode
    chk_ptr_read_addr: assert property (@(posedge mclk) disable iff (!rstn) // [RL13]
        (st_q == DC_IDLE && pf_start) |=> mem_addr == {8'h00, $past(req.op1)})
        else $error("pointer read address wrong");
    // every pointer read stays in page zero, also the second byte
    chk_ptr_page_read: assert property (@(posedge mclk) disable iff (!rstn) // [RL14]
        mem_rd |-> mem_addr[15:8] == 8'h00)
        else $error("pointer byte outside page zero");
    // long indirect indexed waits for memory, no early result
    chk_long_ptr_wait: assert property (@(posedge mclk) disable iff (!rstn) // [RL17]
        (st_q == DC_IDLE && req_valid && req.mode == AM_IIX_L && !req.rmw) |=> !res_valid && mem_rd)
        else $error("long pointer mode answered early");
    // pointer results are clean addresses
    chk_ptr_result_clean: assert property (@(posedge mclk) disable iff (!rstn) // [RL13]
        (st_q == DC_PTR && pf_done) |=> res_valid && !res.illegal && !res.is_imm)
        else $error("pointer result malformed");
    // short indirect gives a page-zero operand address
    chk_short_ind_page: assert property (@(posedge mclk) disable iff (!rstn) // [RL14]
        (st_q == DC_PTR && pf_done && req_q.mode == AM_IND_S) |=> res.addr[15:8] == 8'h00)
        else $error("short indirect left page zero");
    // short indirect indexed keeps the carry but stops at 1fe
    chk_iix_short_top: assert property (@(posedge mclk) disable iff (!rstn) // [RL16]
        (st_q == DC_PTR && pf_done && req_q.mode == AM_IIX_S) |=> res_valid && res.addr <= SHORT_IDX_TOP)
        else $error("short indirect indexed beyond 1fe");
endmodule

// *** verif/amd_mem_model.sv ***
`timescale 1ns/1ps
// memory stand-in that answers pointer reads after a set wait
module amd_mem_model
    import amd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // memory port
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    // bench control and count
    input wire logic [3:0] dly,
    output int nrd
);
    logic [3:0] cnt; // wait cycles spent on this read

    // contents are a fixed function of the whole address
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    // answer off the falling edge; data is scrambled outside the ack cycle
    always @(negedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            cnt <= 4'h0;
            nrd <= 0;
        end
        else if (mem_ack)
        begin
            // one-cycle ack, then the old byte is no longer shown
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= 4'h0;
        end
        else if (mem_rd && cnt >= dly)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= pat(mem_addr);
            nrd <= nrd + 1;
        end
        else if (mem_rd)
        begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// *** verif/cpu_address_mode_decoder_tb_top.sv ***
`timescale 1ns/1ps
// bench top: decoder plus memory model, tasks one per scenario
module cpu_address_mode_decoder_tb_top;
    import amd_pkg::*;
    logic mclk = 1'b0; // 100 MHz
    logic rstn = 1'b0; // async, active low
    logic req_valid = 1'b0;
    amd_req_t req = '0;
    logic req_ready, mem_rd, mem_ack, res_valid;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata;
    amd_res_t res;
    logic [3:0] dly = 4'h0; // memory wait cycles
    int nrd; // reads seen by the model
    int fails = 0;
    int checked = 0;
    int n0; // read count before a step

    amd_decoder uut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .res_valid(res_valid), .res(res));
    amd_mem_model mem (.mclk(mclk), .rstn(rstn), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dly(dly), .nrd(nrd));

    // free-running clock
    always #5 mclk = ~mclk;

    // bench copy of the memory contents
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    task automatic give_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one request, held until taken, then wait for the result pulse
    task automatic issue(input amd_mode_t m, input logic rw, input logic uy, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] x, input logic [7:0] y);
        int i;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge mclk);
        if (i == 50)
        begin
            fails++;
            give_verdict();
        end
        req <= '{m, rw, uy, a, b, x, y};
        req_valid <= 1'b1;
        @(negedge mclk);
        req_valid <= 1'b0;
        for (i = 0; i < 80 && res_valid !== 1'b1; i++) @(negedge mclk);
        if (i == 80)
        begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic t_inh_imm();
        issue(AM_INH, 0, 0, 8'ha5, 8'h5a, 8'h00, 8'h00);
        cmp(16'(res.nbytes), 16'h0000);
        issue(AM_IMM, 0, 0, 8'ha5, 8'h5a, 8'h00, 8'h00);
        cmp(16'(res.imm), 16'h00a5);
        cmp(16'(res.is_imm), 16'h0001);
        cmp(16'(res.nbytes), 16'h0001);
        $display("test inherent/immediate done");
    endtask

    task automatic t_direct();
        issue(AM_DIR_S, 0, 0, 8'hff, 8'h77, 8'h00, 8'h00);
        cmp(res.addr, 16'h00ff);
        cmp(16'(res.nbytes), 16'h0001);
        issue(AM_DIR_L, 0, 0, 8'hab, 8'hcd, 8'h00, 8'h00);
        cmp(res.addr, 16'habcd);
        cmp(16'(res.nbytes), 16'h0002);
        $display("test direct done");
    endtask

    task automatic t_index();
        issue(AM_IDX_0, 0, 0, 8'h11, 8'h22, 8'h7e, 8'h99);
        cmp(res.addr, 16'h007e);
        cmp(16'(res.nbytes), 16'h0000);
        issue(AM_IDX_0, 0, 1, 8'h11, 8'h22, 8'h7e, 8'hc3);
        cmp(res.addr, 16'h00c3);
        issue(AM_IDX_S, 0, 0, 8'hff, 8'h22, 8'hff, 8'h01);
        cmp(res.addr, 16'h01fe);
        cmp(16'(res.nbytes), 16'h0001);
        issue(AM_IDX_L, 0, 1, 8'h12, 8'hf0, 8'h05, 8'h20);
        cmp(res.addr, 16'h1310);
        cmp(16'(res.nbytes), 16'h0002);
        $display("test indexed done");
    endtask

    task automatic t_indirect();
        dly <= 4'h0;
        n0 = nrd;
        issue(AM_IND_S, 0, 0, 8'h40, 8'h00, 8'h00, 8'h00);
        cmp(res.addr, {8'h00, pat(16'h0040)});
        cmp(16'(res.nbytes), 16'h0001);
        cmp(16'(nrd - n0), 16'h0001);
        // slow memory, pointer word straddles the page-zero top
        dly <= 4'h5;
        n0 = nrd;
        issue(AM_IND_L, 0, 0, 8'hff, 8'h00, 8'h00, 8'h00);
        cmp(res.addr, {pat(16'h00ff), pat(16'h0000)});
        cmp(16'(nrd - n0), 16'h0002);
        $display("test indirect done");
    endtask

    task automatic t_indidx();
        dly <= 4'h2;
        issue(AM_IIX_S, 0, 0, 8'hc3, 8'h00, 8'hff, 8'h00);
        cmp(res.addr, 16'h01fe);
        cmp(16'(res.nbytes), 16'h0001);
        issue(AM_IIX_L, 0, 1, 8'h20, 8'h00, 8'h00, 8'hf0);
        cmp(res.addr, 16'h1d0d);
        $display("test indirect indexed done");
    endtask

    task automatic t_rmw();
        n0 = nrd;
        issue(AM_DIR_L, 1, 0, 8'h12, 8'h34, 8'h00, 8'h00);
        cmp(16'(res.illegal), 16'h0001);
        issue(AM_IND_L, 1, 0, 8'h30, 8'h00, 8'h00, 8'h00);
        cmp(16'(res.illegal), 16'h0001);
        cmp(16'(nrd - n0), 16'h0000);
        issue(AM_DIR_S, 1, 0, 8'h12, 8'h34, 8'h00, 8'h00);
        cmp(16'(res.illegal), 16'h0000);
        cmp(res.addr, 16'h0012);
        $display("test read-modify-write done");
    endtask

    // every mode code lands in its family, back to back
    task automatic t_fams();
        amd_fam_t ft[17] = '{FAM_INH, FAM_IMM, FAM_DIR, FAM_DIR, FAM_IDX, FAM_IDX, FAM_IDX,
            FAM_IND, FAM_IND, FAM_IND, FAM_IND, FAM_REL, FAM_REL, FAM_BIT, FAM_BIT, FAM_BIT, FAM_BIT};
        int k;
        for (k = 0; k < 17; k++)
        begin
            issue(amd_mode_t'(k), 0, 0, 8'h10, 8'h20, 8'h00, 8'h00);
            cmp(16'(res.fam), 16'(ft[k]));
        end
        $display("test families done");
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(negedge mclk);
        rstn <= 1'b1;
        t_inh_imm();
        t_direct();
        t_index();
        t_indirect();
        t_indidx();
        t_rmw();
        t_fams();
        give_verdict();
    end
endmodule
